// ---- design/isms_pkg.sv ----
// package for the interrupt split microframe status block: offsets, fields, resets, types
// assumes a 32-bit classic wishbone slave and one descriptor result event per cycle at most
package isms_pkg;
  localparam int UF_N = 8;
  localparam int CNT_W = 8;
  localparam int STAT_W = 3;
  localparam int FRAME_W = 5;
  localparam int UF_IDX_W = 3;
  localparam int ADR_W = 8;
  localparam int IRQ_W = 4;

  localparam logic [7:0] ADDR_RESULT = 8'h00;
  localparam logic [7:0] ADDR_CNT_LO = 8'h04;
  localparam logic [7:0] ADDR_CNT_MID = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_SUMMARY = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

  localparam int START_MASK_LSB = 0;
  localparam int STAT_LSB = 8;
  localparam int CSPLIT_MASK_LSB = 0;
  localparam int CNT_LO_LSB = 8;
  localparam int CNT_LO_N = 3;
  localparam int ST_ERR = 0;
  localparam int ST_BABBLE = 1;
  localparam int ST_UNDER = 2;
  localparam int CTRL_FRAME_LSB = 0;
  localparam int CTRL_DIR_IN = 8;
  localparam int CTRL_CLEAR = 9;
  localparam int SUM_ERR = 0;
  localparam int SUM_BABBLE = 1;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_BABBLE = 2;
  localparam int IRQ_UNDER = 3;

  localparam logic [FRAME_W-1:0] RST_FRAME = 5'h00;
  localparam logic RST_DIR_IN = 1'b1;
  localparam logic [UF_N-1:0] RST_MASK = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;

  typedef struct packed {
    logic valid;
    logic isComplete;
    logic [UF_IDX_W-1:0] uframe;
    logic [FRAME_W-1:0] frame;
    logic [CNT_W-1:0] count;
    logic txErr;
    logic babble;
    logic underrun;
  } isms_event_t;
endpackage

// ---- design/isms_core.sv ----
// interrupt split microframe bookkeeping: masks, per-microframe results, byte counts
// assumes a classic wishbone master and a split engine that reports one result per event
//
// How it works
// - record IN byte count only if start selection bit set and frame matches
// - each byte count is overwritten by the newest captured value
// - counts 2..0 at bits 63..56/55..48/47..40; 4,3 at 79..72/71..64
// - complete mask at bits 39..32; software sets bits, hardware clears after processing
// - mask bit position selects microframe index for start and complete splits
// - eight 3-bit results, microframe 7 at 31..29 down to microframe 0 at 10..8
// - result bit 0 flags a transaction error, for IN and OUT
// - result bit 1 flags babble, IN only
// - result bit 2 flags underrun, OUT only
// - summary babble and error flags are the OR of result bits 1 and 0
`timescale 1ns/10ps
module isms_core #(
  parameter int NUM_UFRAMES = isms_pkg::UF_N
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [isms_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire isms_pkg::isms_event_t splitEvent,
  output logic eventTaken,
  output logic sumBabble,
  output logic sumErr,
  output logic irq
);
  generate
    if (NUM_UFRAMES != isms_pkg::UF_N) begin : gBadSize
      $error("isms_core serves exactly eight microframes");
    end
  endgenerate

  logic [isms_pkg::UF_N-1:0] startMask;
  logic [isms_pkg::UF_N-1:0] startSel;
  logic [isms_pkg::UF_N-1:0] completeMask;
  logic [isms_pkg::UF_N-1:0][isms_pkg::STAT_W-1:0] result;
  logic [isms_pkg::UF_N-1:0][isms_pkg::CNT_W-1:0] rxCount;
  logic [isms_pkg::FRAME_W-1:0] frameExp;
  logic dirIn;
  logic [isms_pkg::IRQ_W-1:0] irqStat;
  logic [isms_pkg::IRQ_W-1:0] irqMask;

  logic [isms_pkg::UF_N-1:0] next_startMask;
  logic [isms_pkg::UF_N-1:0] next_startSel;
  logic [isms_pkg::UF_N-1:0] next_completeMask;
  logic [isms_pkg::UF_N-1:0][isms_pkg::STAT_W-1:0] next_result;
  logic [isms_pkg::UF_N-1:0][isms_pkg::CNT_W-1:0] next_rxCount;
  logic [isms_pkg::FRAME_W-1:0] next_frameExp;
  logic next_dirIn;
  logic [isms_pkg::IRQ_W-1:0] next_irqStat;
  logic [isms_pkg::IRQ_W-1:0] next_irqMask;
  logic [31:0] next_datO;
  logic next_ack;
  logic next_eventTaken;
  logic next_sumBabble;
  logic next_sumErr;
  logic next_irq;

  logic busReq;
  logic busWr;
  logic [31:0] byteMask;
  logic [31:0] wrBits;
  logic frameOk;
  logic startHit;
  logic completeHit;
  logic resultHit;
  logic [isms_pkg::STAT_W-1:0] newResult;
  logic [isms_pkg::IRQ_W-1:0] irqEvents;
  logic [31:0] wordResult;
  logic [31:0] wordCntLo;
  logic [31:0] wordCntMid;
  logic [31:0] wordCntHi;
  logic [isms_pkg::UF_N-1:0] errBits;
  logic [isms_pkg::UF_N-1:0] babbleBits;
  logic [isms_pkg::UF_N-1:0] ufSel;
  logic [isms_pkg::UF_N-1:0] startClr;
  logic [isms_pkg::UF_N-1:0] completeClr;
  logic [isms_pkg::UF_N-1:0] countLoad;
  logic [isms_pkg::UF_N-1:0] resultLoad;
  logic resultClear;

  // ack is dropped the cycle after it is given, so each request gets one answer
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign busWr = busReq & wb_we_i;
  assign byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wrBits = wb_dat_i & byteMask;
  assign resultClear = busWr && wb_adr_i == isms_pkg::ADDR_CTRL
                       && wb_dat_i[isms_pkg::CTRL_CLEAR] && wb_sel_i[1];

  // event qualification
  assign frameOk = splitEvent.frame == frameExp;
  assign startHit = splitEvent.valid & ~splitEvent.isComplete
                    & startMask[splitEvent.uframe] & frameOk;
  assign completeHit = splitEvent.valid & splitEvent.isComplete & dirIn
                       & completeMask[splitEvent.uframe] & frameOk;
  // OUT results arrive with the start split, IN results with the complete split
  assign resultHit = dirIn ? completeHit : startHit;
  assign newResult = {splitEvent.underrun & ~dirIn, splitEvent.babble & dirIn, splitEvent.txErr};

  // per-microframe strobes: mask bit position picks the microframe directly
  for (genvar k = 0; k < isms_pkg::UF_N; k++) begin : gUframe
    assign ufSel[k] = splitEvent.uframe == isms_pkg::UF_IDX_W'(k);
    assign startClr[k] = startHit & ufSel[k];
    assign completeClr[k] = completeHit & ufSel[k];
    assign countLoad[k] = completeClr[k] & startSel[k];
    assign resultLoad[k] = resultHit & ufSel[k];
  end

  // descriptor word images and summary sources
  always_comb begin
    wordResult = '0;
    wordCntLo = '0;
    wordCntMid = '0;
    wordCntHi = '0;
    wordResult[isms_pkg::START_MASK_LSB +: isms_pkg::UF_N] = startMask;
    wordCntLo[isms_pkg::CSPLIT_MASK_LSB +: isms_pkg::UF_N] = completeMask;
    for (int k = 0; k < isms_pkg::UF_N; k++) begin
      wordResult[isms_pkg::STAT_LSB + isms_pkg::STAT_W*k +: isms_pkg::STAT_W] = result[k];
      errBits[k] = result[k][isms_pkg::ST_ERR];
      babbleBits[k] = result[k][isms_pkg::ST_BABBLE];
    end
    for (int k = 0; k < isms_pkg::CNT_LO_N; k++) begin
      wordCntLo[isms_pkg::CNT_LO_LSB + isms_pkg::CNT_W*k +: isms_pkg::CNT_W] = rxCount[k];
    end
    for (int k = isms_pkg::CNT_LO_N; k < isms_pkg::CNT_LO_N + 4; k++) begin
      wordCntMid[isms_pkg::CNT_W*(k-isms_pkg::CNT_LO_N) +: isms_pkg::CNT_W] = rxCount[k];
    end
    wordCntHi[0 +: isms_pkg::CNT_W] = rxCount[isms_pkg::UF_N-1];
  end

  // split bookkeeping
  always_comb begin
    next_startMask = startMask;
    next_startSel = startSel;
    next_completeMask = completeMask;
    next_result = result;
    next_rxCount = rxCount;
    next_frameExp = frameExp;
    next_dirIn = dirIn;
    next_eventTaken = startHit | completeHit;
    // clear goes first, so a result landing in the same cycle is kept
    if (resultClear) begin
      next_result = '0;
      next_rxCount = '0;
      next_startSel = '0;
    end
    // hardware clears first so that a software set in the same cycle wins
    for (int k = 0; k < isms_pkg::UF_N; k++) begin
      if (startClr[k]) begin
        next_startMask[k] = 1'b0;
      end
      if (completeClr[k]) begin
        next_completeMask[k] = 1'b0;
      end
      if (countLoad[k]) begin
        next_rxCount[k] = splitEvent.count;
      end
      if (resultLoad[k]) begin
        next_result[k] = newResult;
      end
    end
    if (busWr) begin
      case (wb_adr_i)
        isms_pkg::ADDR_RESULT: begin
          // software may only raise start bits; the write is ORed in, so written zeros are ignored
          next_startMask = next_startMask | wrBits[isms_pkg::START_MASK_LSB +: isms_pkg::UF_N];
          next_startSel = next_startSel | wrBits[isms_pkg::START_MASK_LSB +: isms_pkg::UF_N];
        end
        isms_pkg::ADDR_CNT_LO: begin
          next_completeMask = next_completeMask
                              | wrBits[isms_pkg::CSPLIT_MASK_LSB +: isms_pkg::UF_N];
        end
        isms_pkg::ADDR_CTRL: begin
          if (wb_sel_i[0]) begin
            next_frameExp = wb_dat_i[isms_pkg::CTRL_FRAME_LSB +: isms_pkg::FRAME_W];
          end
          if (wb_sel_i[1]) begin
            next_dirIn = wb_dat_i[isms_pkg::CTRL_DIR_IN];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      startMask <= isms_pkg::RST_MASK;
      startSel <= isms_pkg::RST_MASK;
      completeMask <= isms_pkg::RST_MASK;
      result <= '0;
      rxCount <= '0;
      frameExp <= isms_pkg::RST_FRAME;
      dirIn <= isms_pkg::RST_DIR_IN;
      eventTaken <= 1'b0;
    end else begin
      startMask <= next_startMask;
      startSel <= next_startSel;
      completeMask <= next_completeMask;
      result <= next_result;
      rxCount <= next_rxCount;
      frameExp <= next_frameExp;
      dirIn <= next_dirIn;
      eventTaken <= next_eventTaken;
    end
  end

  // summary flags trail the results by one cycle
  always_comb begin
    next_sumErr = |errBits;
    next_sumBabble = |babbleBits;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sumErr <= 1'b0;
      sumBabble <= 1'b0;
    end else begin
      sumErr <= next_sumErr;
      sumBabble <= next_sumBabble;
    end
  end

  // interrupt status: sticky, write one to clear, a new event beats the clear
  always_comb begin
    irqEvents = '0;
    irqEvents[isms_pkg::IRQ_DONE] = startHit | completeHit;
    irqEvents[isms_pkg::IRQ_ERR] = resultHit & newResult[isms_pkg::ST_ERR];
    irqEvents[isms_pkg::IRQ_BABBLE] = resultHit & newResult[isms_pkg::ST_BABBLE];
    irqEvents[isms_pkg::IRQ_UNDER] = resultHit & newResult[isms_pkg::ST_UNDER];
    next_irqStat = irqStat;
    next_irqMask = irqMask;
    if (busWr && wb_adr_i == isms_pkg::ADDR_IRQ_STAT) begin
      next_irqStat = irqStat & ~wrBits[isms_pkg::IRQ_W-1:0];
    end
    if (busWr && wb_adr_i == isms_pkg::ADDR_IRQ_MASK && wb_sel_i[0]) begin
      next_irqMask = wb_dat_i[isms_pkg::IRQ_W-1:0];
    end
    next_irqStat = next_irqStat | irqEvents;
    next_irq = |(next_irqStat & next_irqMask);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat <= isms_pkg::RST_IRQ;
      irqMask <= isms_pkg::RST_IRQ;
      irq <= 1'b0;
    end else begin
      irqStat <= next_irqStat;
      irqMask <= next_irqMask;
      irq <= next_irq;
    end
  end

  // bus answer: one cycle after the request, unmapped reads give zero
  always_comb begin
    next_ack = busReq;
    next_datO = wb_dat_o;
    if (busReq && !wb_we_i) begin
      case (wb_adr_i)
        isms_pkg::ADDR_RESULT: next_datO = wordResult;
        isms_pkg::ADDR_CNT_LO: next_datO = wordCntLo;
        isms_pkg::ADDR_CNT_MID: next_datO = wordCntMid;
        isms_pkg::ADDR_CNT_HI: next_datO = wordCntHi;
        isms_pkg::ADDR_CTRL: begin
          next_datO = '0;
          next_datO[isms_pkg::CTRL_FRAME_LSB +: isms_pkg::FRAME_W] = frameExp;
          next_datO[isms_pkg::CTRL_DIR_IN] = dirIn;
        end
        isms_pkg::ADDR_SUMMARY: begin
          next_datO = '0;
          next_datO[isms_pkg::SUM_ERR] = sumErr;
          next_datO[isms_pkg::SUM_BABBLE] = sumBabble;
        end
        isms_pkg::ADDR_IRQ_STAT: next_datO = {{(32-isms_pkg::IRQ_W){1'b0}}, irqStat};
        isms_pkg::ADDR_IRQ_MASK: next_datO = {{(32-isms_pkg::IRQ_W){1'b0}}, irqMask};
        default: next_datO = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_datO;
    end
  end
endmodule

// ---- verification/isms_hub_model.sv ----
// far-side model: hub translator reporting one split result per call
// assumes the bench calls answer() and the core samples valid on mclk
`timescale 1ns/10ps
module isms_hub_model (
  input wire logic mclk,
  output isms_pkg::isms_event_t splitEvent
);
  isms_pkg::isms_event_t last;
  initial splitEvent = '0;
  // released lines carry the inverse, so stale fields are never mistaken for a result
  task automatic answer(input logic cmpl, input logic [2:0] uf, input logic [4:0] fr,
    input logic [7:0] cnt, input logic [2:0] fl);
    @(posedge mclk);
    last = {1'b1, cmpl, uf, fr, cnt, fl};
    splitEvent <= last;
    @(posedge mclk);
    splitEvent <= {1'b0, ~last[19:0]};
  endtask
endmodule

// ---- verification/isms_core_sva.sv ----
// checker: port timing of isms_core
// assumes binding onto isms_core, one clock mclk
`timescale 1ns/10ps
module isms_core_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [isms_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire isms_pkg::isms_event_t splitEvent,
  input wire logic eventTaken,
  input wire logic sumBabble,
  input wire logic sumErr,
  input wire logic irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_taken_valid: assert property (eventTaken |-> $past(splitEvent.valid))
    else $error("event taken without valid");
  a_err_summary: assert property (
    eventTaken && $past(splitEvent.isComplete && splitEvent.txErr) |=> sumErr)
    else $error("error not summarised");
  a_babble_summary: assert property (
    eventTaken && $past(splitEvent.isComplete && splitEvent.babble) |=> sumBabble)
    else $error("babble not summarised");
  a_sum_rise: assert property ($rose(sumErr) || $rose(sumBabble) |-> $past(eventTaken))
    else $error("summary rose without event");
  a_sum_fall: assert property (
    $fell(sumErr) |-> $past(eventTaken || (wb_ack_o && wb_we_i)))
    else $error("summary fell without cause");
  a_irq_rise: assert property ($rose(irq) |-> eventTaken || (wb_ack_o && wb_we_i))
    else $error("irq rose without cause");
  c_taken: cover property (eventTaken);
  c_irq: cover property ($rose(irq));
  c_both: cover property (sumErr && sumBabble);
endmodule

bind isms_core isms_core_sva u_sva (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .splitEvent(splitEvent),
  .eventTaken(eventTaken), .sumBabble(sumBabble), .sumErr(sumErr), .irq(irq));

// ---- verification/isms_core_tb_top.sv ----
// bench for isms_core: wishbone tasks, split results from the hub model
// assumes package, core, hub model and checker compiled first
`timescale 1ns/10ps
module isms_core_tb_top;
  logic mclk, rst_n, cyc, stb, we, ack, taken, sb, se, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  isms_pkg::isms_event_t ev;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  isms_core u_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .splitEvent(ev), .eventTaken(taken), .sumBabble(sb), .sumErr(se), .irq(irq));
  isms_hub_model u_hub (.mclk(mclk), .splitEvent(ev));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // no fixed latency assumed: waits for ack, the global counter cuts a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(what, q, exp);
  endtask
  // flags are {txErr, babble, underrun}
  task automatic evt(input logic c, input logic [2:0] u, input logic [4:0] f,
    input logic [7:0] n, input logic [2:0] fl, input logic exp);
    u_hub.answer(c, u, f, n, fl);
    #1;
    chk("taken", {31'h0, taken}, {31'h0, exp});
  endtask
  task automatic t_reset();
    rd("result", isms_pkg::ADDR_RESULT, 32'h0);
    rd("ctrl", isms_pkg::ADDR_CTRL, 32'h0000_0100);
    wr(8'h20, 32'hffff_ffff);
    rd("unmapped", 8'h20, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_in();
    wr(isms_pkg::ADDR_CTRL, 32'h0000_0103);
    wr(isms_pkg::ADDR_RESULT, 32'h0000_000f);
    wr(isms_pkg::ADDR_CNT_LO, 32'h0000_000c);
    evt(1'b0, 3'h0, 5'h03, 8'h00, 3'b000, 1'b1);
    evt(1'b1, 3'h2, 5'h04, 8'h33, 3'b000, 1'b0);
    evt(1'b1, 3'h2, 5'h03, 8'h5a, 3'b010, 1'b1);
    evt(1'b1, 3'h2, 5'h03, 8'h44, 3'b000, 1'b0);
    evt(1'b1, 3'h3, 5'h03, 8'h11, 3'b100, 1'b1);
    rd("result", isms_pkg::ADDR_RESULT, 32'h0002_800e);
    rd("cnt lo", isms_pkg::ADDR_CNT_LO, 32'h5a00_0000);
    rd("cnt mid", isms_pkg::ADDR_CNT_MID, 32'h0000_0011);
    chk("sum pins", {30'h0, sb, se}, 32'h3);
    wr(isms_pkg::ADDR_CNT_LO, 32'h0000_0004);
    evt(1'b1, 3'h2, 5'h03, 8'h77, 3'b000, 1'b1);
    rd("cnt lo", isms_pkg::ADDR_CNT_LO, 32'h7700_0000);
    rd("summary", isms_pkg::ADDR_SUMMARY, 32'h0000_0001);
    $display("in test done");
  endtask
  task automatic t_out();
    wr(isms_pkg::ADDR_CTRL, 32'h0000_0203);
    wr(isms_pkg::ADDR_IRQ_STAT, 32'h0000_000f);
    wr(isms_pkg::ADDR_IRQ_MASK, 32'h0000_0008);
    wr(isms_pkg::ADDR_RESULT, 32'h0000_0080);
    wr(isms_pkg::ADDR_CNT_LO, 32'h0000_0001);
    evt(1'b0, 3'h7, 5'h03, 8'h00, 3'b001, 1'b1);
    evt(1'b1, 3'h0, 5'h03, 8'h00, 3'b000, 1'b0);
    rd("result", isms_pkg::ADDR_RESULT, 32'h8000_000e);
    rd("irq stat", isms_pkg::ADDR_IRQ_STAT, 32'h0000_0009);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(isms_pkg::ADDR_IRQ_STAT, 32'h0000_0008);
    #1;
    chk("irq off", {31'h0, irq}, 32'h0);
    rd("summary", isms_pkg::ADDR_SUMMARY, 32'h0);
    $display("out test done");
  endtask
  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_in();
    t_out();
    stop_test();
  end
endmodule
